//--- design/fpsv_pkg.sv
package fpsv_pkg;
  // Extended-precision operand layout
  localparam int unsigned FPSV_W        = 80;
  localparam int unsigned FPSV_SIGN_BIT = 79;
  localparam int unsigned FPSV_EXP_HI   = 78;
  localparam int unsigned FPSV_EXP_LO   = 64;
  localparam int unsigned FPSV_INT_BIT  = 63;
  localparam int unsigned FPSV_QNAN_BIT = 62;
  localparam int unsigned FPSV_NREG     = 8;
  localparam int unsigned FPSV_SIG_LSB_DBL = 11;
  localparam int unsigned FPSV_SIG_LSB_SGL = 40;
  localparam logic [14:0] FPSV_EXP_MAX  = 15'h7fff;
  localparam logic [14:0] FPSV_EXP_ONE_LESS = 15'h7ffe;
  // Tag codes
  localparam logic [1:0]  FPSV_TAG_VALID   = 2'h0;
  localparam logic [1:0]  FPSV_TAG_ZERO    = 2'h1;
  localparam logic [1:0]  FPSV_TAG_SPECIAL = 2'h2;
  localparam logic [1:0]  FPSV_TAG_EMPTY   = 2'h3;
  // Control bits
  localparam int unsigned FPSV_INF_CTRL_BIT = 12;
  localparam logic        FPSV_INF_CTRL_RST = 1'b0;
  localparam logic [15:0] FPSV_CTRL_RST     = 16'h037f;
  localparam logic [15:0] FPSV_TAGW_RST     = 16'hffff;
  localparam logic [1:0]  FPSV_RC_ZERO      = 2'h3;
  localparam logic [1:0]  FPSV_PC_SINGLE    = 2'h0;
  localparam logic [1:0]  FPSV_PC_DOUBLE    = 2'h2;
  localparam logic [1:0]  FPSV_PC_EXT       = 2'h3;
  typedef enum logic [2:0] {
    FPSV_OP_ARITH, FPSV_OP_COMPARE, FPSV_OP_STORE_INT, FPSV_OP_STORE_BCD,
    FPSV_OP_TRANSC, FPSV_OP_EXTRACT, FPSV_OP_MOVE
  } fpsv_op_e;
  typedef enum logic [2:0] {
    FPSV_CL_ZERO, FPSV_CL_NORMAL, FPSV_CL_DENORM, FPSV_CL_INF,
    FPSV_CL_QNAN, FPSV_CL_SNAN, FPSV_CL_UNSUPP
  } fpsv_class_e;
endpackage : fpsv_pkg

//--- design/fpsv_unit.sv
`timescale 1ns/1ps
// Notes on behaviour
// - The infinity-control bit is stored and read back, but arithmetic is always affine.
// - A restored tag word marks each register empty for code 11 and non-empty for 00, 01, 10.
// - Operand class for a non-empty register comes from its contents, never from the loaded tag.
// - On a save, every non-empty register gets a tag computed from its actual contents.
// - Unsupported encodings, pseudo-zero and unnormal included, are tagged special (10).
// - Signalling and quiet NaNs are told apart and any generated NaN is quiet.
// - Invalid is raised on a signalling NaN, and on a quiet NaN only for compare and integer or BCD store.
// - Pseudo and unnormal operands are never produced and raise invalid in arithmetic.
// - With denormal masked, denormal operands are normalized before the operation continues.
// - Denormal is raised for transcendental and extract instructions like other arithmetic.
// - Masked overflow with round toward zero gives the largest finite magnitude, not infinity.
// - Unmasked overflow also flags precision, and a stack result is rounded per precision control or opcode.
// - Masked underflow is flagged only when the result is tiny and inexact after denormalizing.
// - Unmasked underflow to the stack keeps the raw exponent and rounds to precision control or extended.
// - Denormal priority among simultaneous exceptions is the same whether masked or not.
module fpsv_unit (
  input  wire logic                         clock,          // Core clock
  input  wire logic                         srst,           // Synchronous reset
  input  wire logic                         ctrl_wr,        // Control word write strobe
  input  wire logic [15:0]                  ctrl_wdata,     // Control word write data
  output logic      [15:0]                  ctrl_rdata,     // Control word readback
  input  wire logic                         tag_load,       // Environment or state restore of tag word
  input  wire logic [15:0]                  tag_wdata,      // Tag word being restored
  input  wire logic                         reg_wr,         // Data register write
  input  wire logic [2:0]                   reg_idx,        // Data register index
  input  wire logic [fpsv_pkg::FPSV_W-1:0]  reg_wdata,      // Data register write value
  input  wire logic                         reg_free,       // Mark written register empty instead
  input  wire logic                         tag_save,       // Environment or state save request
  output logic      [15:0]                  tag_rdata,      // Tag word for the save, registered
  input  wire logic                         op_valid,       // Operation issued by integer core
  input  wire fpsv_pkg::fpsv_op_e           op_kind,        // Instruction group
  input  wire logic [2:0]                   op_src,         // Source register index
  input  wire logic                         op_pc_ignored,  // Opcode ignores precision control
  input  wire logic                         op_to_stack,    // Destination is the register stack
  input  wire logic                         res_valid,      // Raw result from datapath is present
  input  wire logic [fpsv_pkg::FPSV_W-1:0]  res_raw,        // Unbounded-exponent result, rounded
  input  wire logic                         res_ovf,        // Result exponent exceeds range
  input  wire logic                         res_tiny,       // Result is tiny
  input  wire logic                         res_inexact,    // Rounding lost accuracy
  input  wire logic                         res_denorm_loss,// Denormalizing lost accuracy
  output logic                              exc_valid,      // Exception and result outputs valid
  output logic      [5:0]                   exc_flags,      // P U O Z D I event flags of the last request, replaced each time
  output logic                              exc_unmasked,   // An unmasked exception occurred
  output logic      [fpsv_pkg::FPSV_W-1:0]  res_out,        // Final result value
  output logic      [fpsv_pkg::FPSV_W-1:0]  opnd_norm,      // Normalized source operand
  output fpsv_pkg::fpsv_class_e             opnd_class      // Class of the source operand
);
  import fpsv_pkg::*;

  typedef struct packed {
    logic [15:0]                   ctrl;
    logic [FPSV_NREG-1:0]          full;
    logic [FPSV_NREG-1:0][FPSV_W-1:0] regs;
    logic [15:0]                   tagw;
    logic                          ev;
    logic [5:0]                    flags;
    logic                          unm;
    logic [FPSV_W-1:0]             res;
    logic [FPSV_W-1:0]             norm;
    fpsv_class_e                   cls;
  } fpsv_state_s;

  fpsv_state_s st_q, st_d;

  function automatic fpsv_class_e classify(input logic [FPSV_W-1:0] v);
    logic [14:0] e;
    logic        j;
    e = v[FPSV_EXP_HI:FPSV_EXP_LO];
    j = v[FPSV_INT_BIT];
    if (e == 15'h0000) begin
      // Pseudo-denormals are treated like denormals
      classify = (v[FPSV_INT_BIT-1:0] == '0 && !j) ? FPSV_CL_ZERO : FPSV_CL_DENORM;
    end else if (!j) begin
      classify = FPSV_CL_UNSUPP;
    end else if (e == FPSV_EXP_MAX) begin
      if (v[FPSV_QNAN_BIT-1:0] == '0 && !v[FPSV_QNAN_BIT]) classify = FPSV_CL_INF;
      else if (v[FPSV_QNAN_BIT]) classify = FPSV_CL_QNAN;
      else classify = FPSV_CL_SNAN;
    end else begin
      classify = FPSV_CL_NORMAL;
    end
  endfunction : classify

  function automatic logic [1:0] tag_of(input fpsv_class_e c);
    unique case (c)
      FPSV_CL_NORMAL: tag_of = FPSV_TAG_VALID;
      FPSV_CL_ZERO:   tag_of = FPSV_TAG_ZERO;
      default:        tag_of = FPSV_TAG_SPECIAL;
    endcase
  endfunction : tag_of

  logic [2*FPSV_NREG-1:0] tag_now;
  genvar g;
  generate
    for (g = 0; g < FPSV_NREG; g++) begin : g_tag
      assign tag_now[2*g+1:2*g] = st_q.full[g] ? tag_of(classify(st_q.regs[g])) : FPSV_TAG_EMPTY;
    end
  endgenerate

  logic [FPSV_W-1:0] src;
  fpsv_class_e       src_cls;
  logic              is_nan;
  logic              any_nan;
  logic [5:0]        msk;
  logic [5:0]        ev;
  logic [FPSV_W-1:0] r;
  logic [6:0]        lz;
  logic [63:0]       sig;
  logic              sgn;

  assign msk = st_q.ctrl[5:0];
  assign src = st_q.regs[op_src];
  assign src_cls = classify(src);
  assign is_nan  = (src_cls == FPSV_CL_QNAN) || (src_cls == FPSV_CL_SNAN);
  assign any_nan = is_nan;

  always_comb begin
    st_d = st_q;
    ev   = '0;
    r    = src;
    lz   = '0;
    sig  = src[FPSV_INT_BIT:0];
    sgn  = src[FPSV_SIGN_BIT];
    st_d.ev = 1'b0;
    if (ctrl_wr) begin
      st_d.ctrl = ctrl_wdata;
    end
    if (tag_load) begin
      for (int i = 0; i < FPSV_NREG; i++) begin
        st_d.full[i] = (tag_wdata[2*i+:2] != FPSV_TAG_EMPTY);
      end
    end
    if (reg_wr) begin
      st_d.regs[reg_idx] = reg_wdata;
      st_d.full[reg_idx] = !reg_free;
    end
    if (tag_save) begin
      st_d.tagw = tag_now;
    end
    if (op_valid) begin
      if (src_cls == FPSV_CL_SNAN) begin
        ev[0] = 1'b1;
      end
      if (any_nan && (op_kind == FPSV_OP_COMPARE || op_kind == FPSV_OP_STORE_INT ||
                      op_kind == FPSV_OP_STORE_BCD)) begin
        ev[0] = 1'b1;
      end
      if (src_cls == FPSV_CL_UNSUPP && op_kind != FPSV_OP_MOVE) begin
        ev[0] = 1'b1;
      end
      if (src_cls == FPSV_CL_DENORM && op_kind != FPSV_OP_MOVE) begin
        ev[1] = 1'b1;
      end
      if (src_cls == FPSV_CL_DENORM && msk[1]) begin
        for (int k = 63; k >= 0; k--) begin
          if (sig[k] && lz == 7'h00 && !sig[63]) begin
            lz = 7'(63 - k);
          end
        end
        if (sig[63]) begin
          lz = 7'h00;
        end
        sig = sig << lz;
        // Stored exponent goes one-based minus shift, wrapped into the 15-bit exponent field
        r = {sgn, 15'(15'h0001 - 15'(lz)), sig};
      end
      if (is_nan) begin
        r[FPSV_QNAN_BIT] = 1'b1;
      end
      st_d.norm = r;
      st_d.cls  = src_cls;
      // invalid outranks denormal, mask does not matter
      if (ev[0]) begin
        ev[1] = 1'b0;
        r = {1'b1, FPSV_EXP_MAX, 2'b11, 62'h0};
      end
      st_d.res = r;
    end
    if (res_valid) begin
      r = res_raw;
      if (res_ovf) begin
        ev[3] = 1'b1;
        ev[5] = 1'b1;
        if (msk[3]) begin
          if (st_q.ctrl[11:10] == FPSV_RC_ZERO) begin
            r = {res_raw[FPSV_SIGN_BIT], FPSV_EXP_ONE_LESS, 64'hffff_ffff_ffff_ffff};
          end else begin
            r = {res_raw[FPSV_SIGN_BIT], FPSV_EXP_MAX, 1'b1, 63'h0};
          end
        end else begin
          if (op_to_stack && !op_pc_ignored) begin
            if (st_q.ctrl[9:8] == FPSV_PC_SINGLE) r[FPSV_SIG_LSB_SGL-1:0] = '0;
            if (st_q.ctrl[9:8] == FPSV_PC_DOUBLE) r[FPSV_SIG_LSB_DBL-1:0] = '0;
          end
        end
      end else if (res_tiny) begin
        if (msk[4]) begin
          ev[4] = res_denorm_loss;
          ev[5] = res_inexact;
        end else begin
          ev[4] = 1'b1;
          ev[5] = res_inexact;
          if (op_to_stack && !op_pc_ignored) begin
            if (st_q.ctrl[9:8] == FPSV_PC_SINGLE) r[FPSV_SIG_LSB_SGL-1:0] = '0;
            if (st_q.ctrl[9:8] == FPSV_PC_DOUBLE) r[FPSV_SIG_LSB_DBL-1:0] = '0;
          end
        end
      end else begin
        ev[5] = res_inexact;
      end
      st_d.res = r;
    end
    if (op_valid || res_valid) begin
      st_d.ev    = 1'b1;
      st_d.flags = ev;
      st_d.unm   = |(ev & ~msk);
    end
    if (srst) begin
      st_d = '0;
      st_d.ctrl = FPSV_CTRL_RST;
      st_d.ctrl[FPSV_INF_CTRL_BIT] = FPSV_INF_CTRL_RST;
      st_d.tagw = FPSV_TAGW_RST;
      st_d.cls  = FPSV_CL_ZERO;
    end
  end

  always_ff @(posedge clock) begin
    st_q <= st_d;
  end

  assign ctrl_rdata   = st_q.ctrl;
  assign tag_rdata    = st_q.tagw;
  assign exc_valid    = st_q.ev;
  assign exc_flags    = st_q.flags;
  assign exc_unmasked = st_q.unm;
  assign res_out      = st_q.res;
  assign opnd_norm    = st_q.norm;
  assign opnd_class   = st_q.cls;

  chk_ctrl_readback: assert property (@(posedge clock) disable iff (srst)
    ctrl_wr |=> ctrl_rdata == $past(ctrl_wdata)) else $error("control readback wrong");
  chk_tag_load_empty: assert property (@(posedge clock) disable iff (srst)
    tag_load && !reg_wr && tag_wdata[1:0] == FPSV_TAG_EMPTY |=> tag_now[1:0] == FPSV_TAG_EMPTY)
    else $error("empty tag not kept");
  // Any code but empty leaves the register full
  chk_tag_load_full: assert property (@(posedge clock) disable iff (srst)
    tag_load && !reg_wr && tag_wdata[1:0] != FPSV_TAG_EMPTY |=> tag_now[1:0] != FPSV_TAG_EMPTY)
    else $error("full tag read as empty");
  chk_tag_from_data: assert property (@(posedge clock) disable iff (srst)
    tag_save |=> tag_rdata == $past(tag_now)) else $error("saved tag mismatch");
  chk_unsupp_special: assert property (@(posedge clock) disable iff (srst)
    tag_save && st_q.full[0] && classify(st_q.regs[0]) == FPSV_CL_UNSUPP |=> tag_rdata[1:0] == 2'h2)
    else $error("unsupported not special");
  chk_snan_invalid: assert property (@(posedge clock) disable iff (srst)
    op_valid && !res_valid && src_cls == FPSV_CL_SNAN |=> exc_valid && exc_flags[0]) else $error("snan no invalid");
  chk_qnan_quiet: assert property (@(posedge clock) disable iff (srst)
    op_valid && !res_valid && src_cls == FPSV_CL_QNAN && op_kind == FPSV_OP_ARITH |=> !exc_flags[0])
    else $error("qnan raised invalid");
  chk_nan_out_quiet: assert property (@(posedge clock) disable iff (srst)
    op_valid && !res_valid && is_nan |=> res_out[FPSV_QNAN_BIT]) else $error("generated nan not quiet");
  chk_unsupp_invalid: assert property (@(posedge clock) disable iff (srst)
    op_valid && !res_valid && src_cls == FPSV_CL_UNSUPP && op_kind == FPSV_OP_TRANSC |=> exc_flags[0])
    else $error("unsupported no invalid");
  chk_chop_finite: assert property (@(posedge clock) disable iff (srst)
    res_valid && res_ovf && st_q.ctrl[3] && st_q.ctrl[11:10] == FPSV_RC_ZERO && !ctrl_wr
    |=> res_out[FPSV_EXP_HI:FPSV_EXP_LO] == FPSV_EXP_ONE_LESS) else $error("chop overflow gave infinity");
  // Largest finite magnitude has every significand bit set
  chk_chop_sig: assert property (@(posedge clock) disable iff (srst)
    res_valid && res_ovf && st_q.ctrl[3] && st_q.ctrl[11:10] == FPSV_RC_ZERO && !ctrl_wr
    |=> res_out[FPSV_INT_BIT:0] == '1) else $error("chop overflow significand not all ones");
  // Exception valid is low after any cycle with no request
  chk_exc_valid_idle: assert property (@(posedge clock) disable iff (srst)
    !op_valid && !res_valid |=> !exc_valid) else $error("exception valid without request");
  chk_ovf_precision: assert property (@(posedge clock) disable iff (srst)
    res_valid && res_ovf |=> exc_flags[5] && exc_flags[3]) else $error("overflow without precision");
  chk_masked_uflow: assert property (@(posedge clock) disable iff (srst)
    res_valid && !res_ovf && res_tiny && st_q.ctrl[4] && !res_denorm_loss |=> !exc_flags[4])
    else $error("exact tiny flagged underflow");
  chk_denorm_extract: assert property (@(posedge clock) disable iff (srst)
    op_valid && !res_valid && src_cls == FPSV_CL_DENORM && op_kind == FPSV_OP_EXTRACT |=> exc_flags[1])
    else $error("extract missed denormal");
  chk_denorm_norm: assert property (@(posedge clock) disable iff (srst)
    op_valid && src_cls == FPSV_CL_DENORM && st_q.ctrl[1] && src[FPSV_INT_BIT-1:0] != '0
    |=> opnd_norm[FPSV_INT_BIT]) else $error("denormal not normalized");
  chk_denorm_prio: assert property (@(posedge clock) disable iff (srst)
    op_valid && !res_valid && src_cls == FPSV_CL_UNSUPP |=> !exc_flags[1]) else $error("denormal overrode invalid");

  cov_snan: cover property (@(posedge clock) disable iff (srst) op_valid && src_cls == FPSV_CL_SNAN);
  cov_chop_ovf: cover property (@(posedge clock) disable iff (srst) res_valid && res_ovf && st_q.ctrl[11:10] == 2'h3);
  cov_uflow: cover property (@(posedge clock) disable iff (srst) res_valid && res_tiny && !st_q.ctrl[4]);
  cov_save: cover property (@(posedge clock) disable iff (srst) tag_load ##[1:4] tag_save);
  cov_denorm_norm: cover property (@(posedge clock) disable iff (srst) op_valid && src_cls == FPSV_CL_DENORM && st_q.ctrl[1]);
endmodule : fpsv_unit

//--- tb/fpsv_core_model.sv
`timescale 1ns/1ps
module fpsv_core_model (
  input  wire logic                    clock,           // Core clock
  output logic                         op_valid,        // Operation strobe
  output fpsv_pkg::fpsv_op_e           op_kind,         // Instruction group
  output logic [2:0]                   op_src,          // Source register
  output logic                         op_pc_ignored,   // Opcode ignores precision
  output logic                         op_to_stack,     // Result goes to stack
  output logic                         res_valid,       // Datapath result strobe
  output logic [fpsv_pkg::FPSV_W-1:0]  res_raw,         // Datapath result
  output logic                         res_ovf,         // Exponent too large
  output logic                         res_tiny,        // Result tiny
  output logic                         res_inexact,     // Rounding inexact
  output logic                         res_denorm_loss  // Denormalizing inexact
);
  import fpsv_pkg::*;
  initial begin
    op_valid = 1'b0;
    op_kind = FPSV_OP_ARITH;
    op_src = 3'h0;
    op_pc_ignored = 1'b0;
    op_to_stack = 1'b1;
    res_valid = 1'b0;
    res_raw = '0;
    {res_ovf, res_tiny, res_inexact, res_denorm_loss} = 4'h0;
  end
  // Released source and result fields show their inverse; op_kind, the status flags and op_pc_ignored keep the last value
  task automatic issue_op(input fpsv_op_e k, input logic [2:0] s);
    @(negedge clock);
    op_valid <= 1'b1;
    op_kind <= k;
    op_src <= s;
    @(negedge clock);
    op_valid <= 1'b0;
    op_src <= ~s;
  endtask : issue_op
  task automatic issue_res(input logic [79:0] r, input logic [3:0] st, input logic pci);
    @(negedge clock);
    res_valid <= 1'b1;
    res_raw <= r;
    {res_ovf, res_tiny, res_inexact, res_denorm_loss} <= st;
    op_pc_ignored <= pci;
    @(negedge clock);
    res_valid <= 1'b0;
    res_raw <= ~r;
  endtask : issue_res
endmodule : fpsv_core_model

//--- tb/fpu_special_value_exceptions_tb.sv
`timescale 1ns/1ps
module fpu_special_value_exceptions_tb;
  import fpsv_pkg::*;
  logic clock, srst, ctrl_wr, tag_load, reg_wr, reg_free, tag_save, du;
  logic op_valid, op_pc_ignored, op_to_stack, res_valid, exc_valid, exc_unmasked;
  logic res_ovf, res_tiny, res_inexact, res_denorm_loss;
  logic [15:0] ctrl_wdata, ctrl_rdata, tag_wdata, tag_rdata, ldtag, exptag, cw;
  logic [2:0]  reg_idx, op_src;
  logic [5:0]  exc_flags;
  logic [79:0] reg_wdata, res_raw, res_out, opnd_norm, rv;
  fpsv_op_e    op_kind;
  fpsv_class_e opnd_class;
  fpsv_class_e regc[8];
  int          mismatches = 0;
  int          tests_run = 0;
  integer      seed = 32'h7fc69b19;

  fpsv_unit dut (.clock, .srst, .ctrl_wr, .ctrl_wdata, .ctrl_rdata, .tag_load, .tag_wdata, .reg_wr,
    .reg_idx, .reg_wdata, .reg_free, .tag_save, .tag_rdata, .op_valid, .op_kind, .op_src,
    .op_pc_ignored, .op_to_stack, .res_valid, .res_raw, .res_ovf, .res_tiny, .res_inexact,
    .res_denorm_loss, .exc_valid, .exc_flags, .exc_unmasked, .res_out, .opnd_norm, .opnd_class);
  fpsv_core_model core (.clock, .op_valid, .op_kind, .op_src, .op_pc_ignored, .op_to_stack,
    .res_valid, .res_raw, .res_ovf, .res_tiny, .res_inexact, .res_denorm_loss);

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  function automatic logic [79:0] rnd80();
    logic [95:0] r;
    r = {$random(seed), $random(seed), $random(seed)};
    return r[79:0];
  endfunction : rnd80
  function automatic logic [79:0] mk(input fpsv_class_e c, input logic [79:0] r);
    case (c)
      FPSV_CL_ZERO:   mk = {r[79], 79'h0};
      FPSV_CL_NORMAL: mk = {r[79], 1'b0, r[77:65], 1'b1, 1'b1, r[62:0]};
      FPSV_CL_DENORM: mk = {r[79], 15'h0, 1'b0, r[62:1], 1'b1};
      FPSV_CL_INF:    mk = {r[79], 15'h7fff, 1'b1, 63'h0};
      FPSV_CL_QNAN:   mk = {r[79], 15'h7fff, 2'b11, r[61:0]};
      FPSV_CL_SNAN:   mk = {r[79], 15'h7fff, 2'b10, r[61:1], 1'b1};
      default:        mk = {r[79], r[78:65], 1'b1, 1'b0, r[62:0]};
    endcase
  endfunction : mk
  // Significand kept after rounding to the selected precision
  function automatic logic [63:0] rsig(input logic [63:0] s, input logic [1:0] pc, input logic pci);
    rsig = s;
    if (!pci && pc == FPSV_PC_SINGLE) rsig[39:0] = '0;
    if (!pci && pc == FPSV_PC_DOUBLE) rsig[10:0] = '0;
  endfunction : rsig

  task automatic cmp_bit(input string n, input logic e, input logic g);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : cmp_bit
  task automatic cmp_vec(input string n, input logic [79:0] e, input logic [79:0] g);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : cmp_vec
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : conclude
  // One-hot strobe {ctrl_wr, reg_wr, tag_load, tag_save} for one cycle
  task automatic pulse(input logic [3:0] w);
    @(negedge clock);
    {ctrl_wr, reg_wr, tag_load, tag_save} = w;
    @(negedge clock);
    {ctrl_wr, reg_wr, tag_load, tag_save} = 4'h0;
  endtask : pulse
  task automatic check_op(input fpsv_class_e c, input int k);
    logic inv, den, dchk;
    inv = c == FPSV_CL_SNAN || (c == FPSV_CL_QNAN && k inside {1, 2, 3}) || (c == FPSV_CL_UNSUPP && k == 0);
    den = c == FPSV_CL_DENORM && k inside {0, 4, 5};
    dchk = !(c == FPSV_CL_UNSUPP && k != 0) && !(c == FPSV_CL_DENORM && !den);
    cmp_bit("exc valid", 1'b1, exc_valid);
    cmp_vec("operand class", {77'h0, c}, {77'h0, opnd_class});
    if (dchk) cmp_bit("invalid flag", inv, exc_flags[0]);
    if (dchk) cmp_bit("denormal flag", den, exc_flags[1]);
    if (dchk) cmp_bit("unmasked", den & du, exc_unmasked);
    if (c == FPSV_CL_DENORM && !du) cmp_bit("normalized", 1'b1, opnd_norm[63]);
    if (k == 0 && c inside {FPSV_CL_SNAN, FPSV_CL_QNAN}) cmp_vec("nan result", 80'h1ffff, {63'h0, res_out[78:62]});
  endtask : check_op

  initial begin
    {srst, ctrl_wr, tag_load, reg_wr, reg_free, tag_save} = 6'h20;
    {ctrl_wdata, tag_wdata, reg_idx, reg_wdata} = '0;
    repeat (3) @(negedge clock);
    srst = 1'b0;
    cmp_vec("ctrl reset", 80'h037f, {64'h0, ctrl_rdata});
    cmp_vec("tag reset", 80'hffff, {64'h0, tag_rdata});
    for (int i = 0; i < 8; i++) begin
      cw = 16'($random(seed));
      cw[12] = i[0];
      ctrl_wdata = cw;
      pulse(4'h8);
      cmp_vec("ctrl word", {64'h0, cw & 16'h1f3f}, {64'h0, ctrl_rdata & 16'h1f3f});
    end
    $display("control word test done");
    for (int rd = 0; rd < 4; rd++) begin
      du = rd[0];
      ctrl_wdata = du ? 16'h037d : 16'h037f;
      pulse(4'h8);
      for (int i = 0; i < 8; i++) begin
        regc[i] = fpsv_class_e'({$random(seed)} % 7);
        reg_idx = i[2:0];
        reg_wdata = mk(regc[i], rnd80());
        pulse(4'h4);
      end
      ldtag = 16'($random(seed));
      tag_wdata = ldtag;
      pulse(4'h2);
      reg_idx = 3'h7;
      reg_free = 1'b1;
      pulse(4'h4);
      reg_free = 1'b0;
      ldtag[15:14] = 2'h3;
      pulse(4'h1);
      for (int i = 0; i < 8; i++) begin
        exptag[2*i+:2] = (ldtag[2*i+:2] == 2'h3) ? FPSV_TAG_EMPTY : (regc[i] == FPSV_CL_ZERO) ? FPSV_TAG_ZERO :
          (regc[i] == FPSV_CL_NORMAL) ? FPSV_TAG_VALID : FPSV_TAG_SPECIAL;
      end
      cmp_vec("tag word", {64'h0, exptag}, {64'h0, tag_rdata});
      for (int i = 0; i < 7; i++) begin
        for (int k = 0; k < 6; k++) begin
          if (ldtag[2*i+:2] != 2'h3) begin
            core.issue_op(fpsv_op_e'(k), i[2:0]);
            check_op(regc[i], k);
          end
        end
      end
    end
    $display("tag and operand test done");
    for (int s = 0; s < 2; s++) begin
      ctrl_wdata = 16'h0f7f;
      pulse(4'h8);
      rv = rnd80();
      rv[79] = s[0];
      core.issue_res(rv, 4'ha, 1'b0);
      cmp_vec("overflow result", {rv[79], 15'h7ffe, {64{1'b1}}}, res_out);
      cmp_bit("overflow flag", 1'b1, exc_flags[3]);
    end
    for (int t = 0; t < 4; t++) begin
      ctrl_wdata = 16'h037f;
      pulse(4'h8);
      core.issue_res(rnd80(), {1'b0, t[1], 1'b1, t[0]}, 1'b0);
      cmp_bit("masked underflow", t[1] & t[0], exc_flags[4]);
    end
    for (int p = 0; p < 4; p++) begin
      for (int v = 0; v < 4; v++) begin
        if (p != 1) begin
          ctrl_wdata = (v[1] ? 16'h006f : 16'h0077) | {6'h0, p[1:0], 8'h0};
          pulse(4'h8);
          rv = rnd80();
          core.issue_res(rv, v[1] ? 4'h7 : 4'ha, v[0]);
          cmp_bit("exception flag", 1'b1, exc_flags[v[1] ? 4 : 3]);
          if (!v[1]) cmp_bit("precision flag", 1'b1, exc_flags[5]);
          cmp_bit("unmasked", 1'b1, exc_unmasked);
          cmp_vec("significand", {16'h0, rsig(rv[63:0], p[1:0], v[0])}, {16'h0, res_out[63:0]});
        end
      end
    end
    $display("result test done");
    conclude();
  end

  initial begin
    #200000;
    mismatches++;
    conclude();
  end
endmodule : fpu_special_value_exceptions_tb
